// ===== logic/sfcd_decoder.sv
/*
 Command decoder and mode register of a synchronous flash on an SDRAM-style
 bus. Assumes pins are driven synchronously to sys_clk by the bus controller;
 the boot-block read path is re-timed here onto sys_clk.
*/
// Overview of operation
// - Mode program: row, column and mode strobes low
// - Row strobe latches row; column starts read
// - Precharge pattern stops burst only while reading
// - Deselect or all strobes high is no-op
// - Clock gate fall enters, rise exits standby
// - Power-down only after 60 us idle
// - Gate low while busy means suspend
// - Output mask hides data two cycles later
// - Width pin picks 32 or 16 bits
// - Program/erase: column strobe with write low
// - Address bit 7 selects identification reads
// - Continuity test entered, left by code
// - Boot block reads follow select and mask
// - Boot block program uses synchronous commands
// - Bits seven, six, two: target, row latency, order
// - Bits five-three column latency; one-zero length
// - Gate low freezes outputs and burst state outside boot mode
// - Burst order sequential or interleaved modulo length
`timescale 1ns/100ps
module sfcd_decoder #(
   parameter int IDLE_LIMIT = sfcd_pkg::IDLE_CYCLES,
   parameter logic [15:0] MAKER_CODE = 16'h005a,   // Arbitrary value
   parameter logic [15:0] PART_CODE = 16'h00c3     // Arbitrary value
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Command strobes
   input wire logic clock_gate,
   input wire logic chip_select_n,
   input wire logic row_strobe_n,
   input wire logic col_strobe_n,
   input wire logic mode_register_strobe_n,
   input wire logic write_strobe_n,
   input wire logic output_mask,
   input wire logic width_select,
   input wire logic fast_supply,
   input wire logic [sfcd_pkg::ADDR_W-1:0] addr,
   // Array side
   input wire logic [sfcd_pkg::DATA_W-1:0] array_data,
   input wire logic [sfcd_pkg::BOOT_W-1:0] boot_data,
   // Data pins
   output logic [sfcd_pkg::DATA_W-1:0] dq_out,
   output logic dq_oe,
   // Status and requests
   output logic [sfcd_pkg::ADDR_W-1:0] row_addr,
   output logic [sfcd_pkg::ADDR_W-1:0] col_addr,
   output logic [2:0] burst_addr,
   output logic burst_active,
   output logic prog_req,
   output logic prog_fast,
   output logic continuity_test,
   output logic double_width_mode,
   output logic boot_mode,
   output logic power_down,
   output logic clock_suspend,
   output logic [sfcd_pkg::MODE_W-1:0] burst_latency_setup
);
   // ****************************************
   // Input synchronisers for the async boot path
   // ****************************************
   logic [2:0] cs_sync;
   logic [2:0] mask_sync;
   logic async_cs_n;
   logic async_mask;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         cs_sync <= 3'h7;
         mask_sync <= 3'h7;
      end else begin
         cs_sync <= {cs_sync[1:0], chip_select_n};
         mask_sync <= {mask_sync[1:0], output_mask};
      end
   end

   // A change counts only when the last two stages agree
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         async_cs_n <= 1'b1;
         async_mask <= 1'b1;
      end else begin
         if (cs_sync[1] == cs_sync[2]) begin
            async_cs_n <= cs_sync[2];
         end
         if (mask_sync[1] == mask_sync[2]) begin
            async_mask <= mask_sync[2];
         end
      end
   end

   // ****************************************
   // Command decode
   // ****************************************
   logic gate_prev;
   sfcd_pkg::cmd_e cmd;
   logic [sfcd_pkg::MODE_W-1:0] mode;

   always_comb begin
      cmd = sfcd_pkg::CMD_NOP;
      if (gate_prev && !chip_select_n) begin
         unique case ({row_strobe_n, col_strobe_n, mode_register_strobe_n})
            3'b000: cmd = sfcd_pkg::CMD_MODE;
            3'b011: cmd = sfcd_pkg::CMD_ROW;
            3'b010: cmd = sfcd_pkg::CMD_STOP;
            3'b101, 3'b100: begin
               if (!write_strobe_n) begin
                  cmd = sfcd_pkg::CMD_PROG;
               end else if (mode_register_strobe_n) begin
                  cmd = sfcd_pkg::CMD_READ;
               end
            end
            default: cmd = sfcd_pkg::CMD_NOP;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         gate_prev <= 1'b1;
      end else begin
         gate_prev <= clock_gate;
      end
   end

   // ****************************************
   // Mode register and width strap
   // ****************************************
   logic width_caught;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         mode <= sfcd_pkg::MODE_RESET;
      end else if (cmd == sfcd_pkg::CMD_MODE) begin
         mode <= addr[sfcd_pkg::MODE_W-1:0];
      end
   end

   // Width is caught once after reset; later changes are ignored
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         width_caught <= 1'b0;
         double_width_mode <= 1'b0;
      end else if (!width_caught) begin
         width_caught <= 1'b1;
         double_width_mode <= width_select;
      end
   end

   assign burst_latency_setup = mode;

   // ****************************************
   // Standby and idle timer
   // ****************************************
   logic [$clog2(sfcd_pkg::IDLE_CYCLES+1)-1:0] idle_cnt;
   logic idle_long;
   logic busy;
   logic row_open;

   assign idle_long = (idle_cnt >= IDLE_LIMIT[$bits(idle_cnt)-1:0]);
   assign busy = burst_active || row_open;

   always_ff @(posedge sys_clk) begin
      if (reset || cmd != sfcd_pkg::CMD_NOP) begin
         idle_cnt <= '0;
      end else if (!idle_long) begin
         idle_cnt <= idle_cnt + 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         power_down <= 1'b0;
         clock_suspend <= 1'b0;
      end else if (gate_prev && !clock_gate) begin
         power_down <= idle_long && !busy;
         clock_suspend <= !(idle_long && !busy);
      end else if (!gate_prev && clock_gate) begin
         power_down <= 1'b0;
         clock_suspend <= 1'b0;
      end
   end

   // ****************************************
   // Addresses, burst and program requests
   // ****************************************
   sfcd_burst_if bif();

   sfcd_burst_seq u_seq (
      .sys_clk(sys_clk),
      .reset(reset),
      .bus(bif.seq)
   );

   assign bif.start = (cmd == sfcd_pkg::CMD_READ) && !continuity_test;
   assign bif.stop = (cmd == sfcd_pkg::CMD_STOP) && bif.active;
   assign bif.hold = !gate_prev;
   assign bif.interleave = mode[sfcd_pkg::BIT_ORDER];
   assign bif.length = (mode[sfcd_pkg::BL_HI:sfcd_pkg::BL_LO] == sfcd_pkg::BL_CODE_8) ?
      sfcd_pkg::BURST_LEN_8 : sfcd_pkg::BURST_LEN_4;
   assign bif.start_addr = addr[2:0];

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         row_addr <= '0;
         row_open <= 1'b0;
      end else if (cmd == sfcd_pkg::CMD_ROW) begin
         row_addr <= addr;
         row_open <= 1'b1;
      end else if (cmd == sfcd_pkg::CMD_STOP || cmd == sfcd_pkg::CMD_MODE) begin
         row_open <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         col_addr <= '0;
      end else if (cmd == sfcd_pkg::CMD_READ || cmd == sfcd_pkg::CMD_PROG) begin
         col_addr <= addr;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         burst_active <= 1'b0;
         burst_addr <= 3'h0;
      end else begin
         burst_active <= bif.active;
         burst_addr <= bif.beat_addr;
      end
   end

   // Program requests pass even in boot mode; select high or gate low blocks both, continuity test blocks prog_req but not prog_fast
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         prog_req <= 1'b0;
         prog_fast <= 1'b0;
      end else begin
         prog_req <= (cmd == sfcd_pkg::CMD_PROG) && !continuity_test;
         prog_fast <= (cmd == sfcd_pkg::CMD_PROG) && fast_supply;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         continuity_test <= 1'b0;
      end else if (continuity_test &&
                   (addr & sfcd_pkg::CT_EXIT_MASK) == sfcd_pkg::CT_EXIT_CODE) begin
         continuity_test <= 1'b0;
      end else if (cmd == sfcd_pkg::CMD_PROG && addr[sfcd_pkg::ADDR_W-1]) begin
         continuity_test <= 1'b1;
      end
   end

   logic next_boot_mode;
   assign next_boot_mode = (mode[sfcd_pkg::BL_HI:sfcd_pkg::BL_LO] == sfcd_pkg::BL_CODE_BOOT);

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         boot_mode <= 1'b0;
      end else begin
         boot_mode <= next_boot_mode;
      end
   end

   // ****************************************
   // Data output and mask pipeline
   // ****************************************
   logic [sfcd_pkg::MASK_DELAY-1:0] mask_pipe;
   logic [sfcd_pkg::DATA_W-1:0] read_word;

   always_comb begin
      if (mode[sfcd_pkg::BIT_ID_READ]) begin
         read_word = {PART_CODE, MAKER_CODE};
      end else if (double_width_mode) begin
         read_word = array_data;
      end else begin
         read_word = {16'h0000, col_addr[0] ? array_data[31:16] : array_data[15:0]};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         mask_pipe <= '1;
      end else if (gate_prev) begin
         mask_pipe <= {mask_pipe[0], output_mask};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         dq_out <= '0;
         dq_oe <= 1'b0;
      end else if (boot_mode) begin
         dq_out <= {16'h0000, boot_data};
         dq_oe <= !async_cs_n && !async_mask;
      end else if (gate_prev) begin
         dq_out <= read_word;
         dq_oe <= bif.active && !mask_pipe[sfcd_pkg::MASK_DELAY-1];
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   property p_mask_hides;
      @(posedge sys_clk) disable iff (reset)
      (gate_prev && output_mask && !boot_mode) ##1 (gate_prev && !boot_mode)[*2]
         |=> !dq_oe;
   endproperty
   a_mask_hides: assert property (p_mask_hides) else $error("mask did not hide data");

   property p_mode_load;
      @(posedge sys_clk) disable iff (reset)
      (cmd == sfcd_pkg::CMD_MODE) |=> (mode == $past(addr[7:0]));
   endproperty
   a_mode_load: assert property (p_mode_load) else $error("mode not loaded");

   property p_row_latch;
      @(posedge sys_clk) disable iff (reset)
      (gate_prev && !chip_select_n && !row_strobe_n && col_strobe_n && mode_register_strobe_n)
         |=> (row_addr == $past(addr));
   endproperty
   a_row_latch: assert property (p_row_latch) else $error("row not latched");

   property p_stop;
      @(posedge sys_clk) disable iff (reset)
      (cmd == sfcd_pkg::CMD_STOP) |=> !bif.active;
   endproperty
   a_stop: assert property (p_stop) else $error("burst not stopped");

   property p_ignore_gated;
      @(posedge sys_clk) disable iff (reset)
      !gate_prev && !chip_select_n && !row_strobe_n && col_strobe_n |=> $stable(row_addr);
   endproperty
   a_ignore_gated: assert property (p_ignore_gated) else $error("decode while gated");

   property p_deselect;
      @(posedge sys_clk) disable iff (reset)
      chip_select_n |=> $stable(mode) && !prog_req;
   endproperty
   a_deselect: assert property (p_deselect) else $error("deselect acted");

   property p_suspend;
      @(posedge sys_clk) disable iff (reset)
      (gate_prev && !clock_gate && busy) |=> clock_suspend && !power_down;
   endproperty
   a_suspend: assert property (p_suspend) else $error("no suspend");

   property p_pd_idle;
      @(posedge sys_clk) disable iff (reset)
      $rose(power_down) |-> $past(idle_long);
   endproperty
   a_pd_idle: assert property (p_pd_idle) else $error("early power-down");

   sequence s_freeze;
      !gate_prev && !boot_mode;
   endsequence
   property p_freeze;
      @(posedge sys_clk) disable iff (reset)
      s_freeze |=> $stable(dq_out) || boot_mode;
   endproperty
   a_freeze: assert property (p_freeze) else $error("output moved in suspend");
endmodule // sfcd_decoder

// ===== pkg/sfcd_pkg.sv
/*
 Constants, mode register layout and command encodings for the synchronous
 flash command decoder. Assumes a single 20 MHz system clock.
*/
package sfcd_pkg;
   // ****************************************
   // Mode register layout
   // ****************************************
   localparam int MODE_W = 8;
   localparam int BIT_ID_READ = 7;
   localparam int BIT_ROW_LAT = 6;
   localparam int CL_HI = 5;
   localparam int CL_LO = 3;
   localparam int BIT_ORDER = 2;
   localparam int BL_HI = 1;
   localparam int BL_LO = 0;
   localparam logic [MODE_W-1:0] MODE_RESET = 8'h0059;
   localparam logic [2:0] CL_RESERVED = 3'h0;
   localparam logic [1:0] BL_CODE_4 = 2'h1;
   localparam logic [1:0] BL_CODE_8 = 2'h2;
   localparam logic [1:0] BL_CODE_BOOT = 2'h3;
   localparam logic [1:0] BL_RESERVED = 2'h0;
   localparam logic [3:0] BURST_LEN_4 = 4'h4;
   localparam logic [3:0] BURST_LEN_8 = 4'h8;
   // ****************************************
   // Address and data widths and exit code
   // ****************************************
   localparam int ADDR_W = 13;
   localparam int DATA_W = 32;
   localparam int BOOT_W = 16;
   localparam logic [ADDR_W-1:0] CT_EXIT_MASK = 13'h1c07;
   localparam logic [ADDR_W-1:0] CT_EXIT_CODE = 13'h0805;
   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_HZ = 20_000_000;
   localparam int IDLE_US = 60;
   localparam int IDLE_CYCLES = (CLK_HZ / 1_000_000) * IDLE_US;
   localparam int MRS_GAP = 3;
   localparam int MASK_DELAY = 2;
   localparam logic [MODE_W-1:0] ID_SHIFT = 8'h0001;
   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [2:0] {
      CMD_NOP, CMD_MODE, CMD_ROW, CMD_READ, CMD_STOP, CMD_PROG
   } cmd_e;
   typedef enum logic [1:0] {ST_RUN, ST_POWER_DOWN, ST_SUSPEND} standby_e;
endpackage

// ===== pkg/sfcd_burst_if.sv
/*
 Carrier between the command decoder and its burst address sequencer.
 Assumes both ends share the system clock.
*/
`timescale 1ns/100ps
interface sfcd_burst_if;
   logic start;
   logic stop;
   logic hold;
   logic interleave;
   logic [3:0] length;
   logic [2:0] start_addr;
   logic active;
   logic [2:0] beat_addr;
   modport ctrl (output start, stop, hold, interleave, length, start_addr,
      input active, beat_addr);
   modport seq (input start, stop, hold, interleave, length, start_addr,
      output active, beat_addr);
endinterface

// ===== logic/sfcd_burst_seq.sv
/*
 Burst address sequencer: walks the low column bits in sequential or
 interleaved order. Assumes the controller gives lengths of 4 or 8 only.
*/
`timescale 1ns/100ps
module sfcd_burst_seq (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Controller side
   sfcd_burst_if.seq bus
);
   logic [3:0] beat;
   logic [3:0] len;
   logic [2:0] base;
   logic ilv;
   logic [2:0] mask;
   logic [2:0] offs;

   assign mask = (len == sfcd_pkg::BURST_LEN_8) ? 3'h7 : 3'h3;
   assign offs = ilv ? (base ^ beat[2:0]) : (base + beat[2:0]);
   assign bus.beat_addr = (base & ~mask) | (offs & mask);

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         bus.active <= 1'b0;
         beat <= 4'h0;
         len <= sfcd_pkg::BURST_LEN_4;
         base <= 3'h0;
         ilv <= 1'b0;
      end else if (bus.start) begin
         bus.active <= 1'b1;
         beat <= 4'h0;
         len <= bus.length;
         base <= bus.start_addr;
         ilv <= bus.interleave;
      end else if (bus.stop) begin
         bus.active <= 1'b0;
      end else if (bus.active && !bus.hold) begin
         beat <= beat + 4'h1;
         if (beat + 4'h1 == len) begin
            bus.active <= 1'b0;
         end
      end
   end
endmodule // sfcd_burst_seq

// ===== tb/sfcd_host.sv
/*
 Host model: bus controller driving the decoder's command pins.
 Assumes one shared clock; pins change just after rising edges.
*/
`timescale 1ns/100ps
module sfcd_host (
   // Clock
   input wire logic sys_clk,
   // Command pins
   output logic clock_gate,
   output logic chip_select_n,
   output logic row_strobe_n,
   output logic col_strobe_n,
   output logic mode_register_strobe_n,
   output logic write_strobe_n,
   output logic output_mask,
   output logic [12:0] addr
);
   // ****************************************
   // Pin drivers
   // ****************************************
   initial begin
      clock_gate = 1'b1;
      chip_select_n = 1'b1;
      {row_strobe_n, col_strobe_n, mode_register_strobe_n, write_strobe_n} = 4'hf;
      output_mask = 1'b1;
      addr = 13'h0000;
   end
   // Pattern is row, column, mode, write strobe
   task automatic cmd(input logic [3:0] p, input logic [12:0] a);
      @(posedge sys_clk);
      chip_select_n <= 1'b0;
      {row_strobe_n, col_strobe_n, mode_register_strobe_n, write_strobe_n} <= p;
      addr <= a;
      @(posedge sys_clk);
      chip_select_n <= 1'b1;
      {row_strobe_n, col_strobe_n, mode_register_strobe_n, write_strobe_n} <= 4'hf;
      // Released bus shows the inverse, never a stale copy
      addr <= ~a;
   endtask
   // Only called between operations, with the gate high
   task automatic mode(input logic [7:0] k);
      cmd(4'h0, {5'h00, k});
      repeat (3) @(posedge sys_clk);
   endtask
   task automatic pins(input logic g, input logic m, input logic c);
      @(posedge sys_clk);
      clock_gate <= g;
      output_mask <= m;
      chip_select_n <= c;
   endtask
endmodule // sfcd_host

// ===== tb/tb_sync_flash_command_decoder.sv
/*
 Self-checking bench for the flash command decoder and its host model.
 Assumes one 20 MHz clock shared by decoder and host.
*/
`timescale 1ns/100ps
module tb_sync_flash_command_decoder;
   // ****************************************
   // Signals
   // ****************************************
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic clock_gate, chip_select_n, row_strobe_n, col_strobe_n, output_mask;
   logic mode_register_strobe_n, write_strobe_n, width_select, fast_supply;
   logic [12:0] addr, row_addr, col_addr, row_key, col_key;
   logic [31:0] array_data, dq_out, word;
   logic [15:0] boot_data;
   logic [7:0] burst_latency_setup, key;
   logic [2:0] burst_addr, held;
   logic dq_oe, burst_active, prog_req, prog_fast, continuity_test;
   logic double_width_mode, boot_mode, power_down, clock_suspend;
   int fail_count = 0;
   int check_count = 0;
   int cycles = 0;
   int n, m;
   int q[$];
   // Short idle limit keeps the power-down case quick; identity codes arbitrary
   sfcd_decoder #(.IDLE_LIMIT(8), .MAKER_CODE(16'h3c5a), .PART_CODE(16'h0f96)) dut_u (
      .sys_clk(sys_clk), .reset(reset), .clock_gate(clock_gate),
      .chip_select_n(chip_select_n), .row_strobe_n(row_strobe_n),
      .col_strobe_n(col_strobe_n), .mode_register_strobe_n(mode_register_strobe_n),
      .write_strobe_n(write_strobe_n), .output_mask(output_mask),
      .width_select(width_select), .fast_supply(fast_supply), .addr(addr),
      .array_data(array_data), .boot_data(boot_data), .dq_out(dq_out), .dq_oe(dq_oe),
      .row_addr(row_addr), .col_addr(col_addr), .burst_addr(burst_addr),
      .burst_active(burst_active), .prog_req(prog_req), .prog_fast(prog_fast),
      .continuity_test(continuity_test), .double_width_mode(double_width_mode),
      .boot_mode(boot_mode), .power_down(power_down), .clock_suspend(clock_suspend),
      .burst_latency_setup(burst_latency_setup));
   sfcd_host host_u (
      .sys_clk(sys_clk), .clock_gate(clock_gate), .chip_select_n(chip_select_n),
      .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n),
      .mode_register_strobe_n(mode_register_strobe_n), .write_strobe_n(write_strobe_n),
      .output_mask(output_mask), .addr(addr));
   always #25 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         end_of_test();
      end
   end
   // ****************************************
   // Tasks
   // ****************************************
   task automatic end_of_test();
      if (fail_count == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask
   task automatic beats(input int k, input int bl);
      for (int i = 0; i < k; i++) begin
         chk(burst_addr & (bl - 1), q.pop_front());
         tick(1);
      end
   endtask
   // Program mode, open a row, start a read; build the beat order
   task automatic start_read(input bit il, input int bl, input bit id);
      row_key = 13'($urandom);
      col_key = 13'($urandom);
      key = {id, 1'($urandom), 3'($urandom_range(7, 1)), il, (bl == 8) ? 2'h2 : 2'h1};
      host_u.mode(key);
      chk(burst_latency_setup, key);
      host_u.cmd(4'h7, row_key);
      host_u.cmd(4'hb, col_key);
      q = {};
      for (int i = 0; i < bl; i++) begin
         if (il)
            q.push_back((col_key[2:0] ^ i) & (bl - 1));
         else
            q.push_back((col_key[2:0] + i) & (bl - 1));
      end
      n = 0;
      while (burst_active !== 1'b1 && n < 30) begin
         tick(1);
         n++;
      end
      chk(burst_active, 1'b1);
      chk(row_addr, row_key);
      chk(col_addr, col_key);
   endtask
   task automatic prog(input bit f, input logic [12:0] a);
      @(posedge sys_clk);
      fast_supply <= f;
      host_u.cmd(4'ha, a);
      n = 0;
      m = 0;
      repeat (4) begin
         #1;
         n += prog_req;
         m += prog_fast;
         @(posedge sys_clk);
      end
      chk(n, 1);
      chk(m, f);
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   initial begin
      void'($urandom(18));
      width_select <= 1'($urandom);
      fast_supply <= 1'b0;
      array_data <= $urandom;
      boot_data <= 16'($urandom);
      repeat (10) @(posedge sys_clk);
      reset <= 1'b0;
      tick(1);
      chk(burst_latency_setup, 8'h59);
      chk({burst_active, dq_oe, power_down, continuity_test}, 4'h0);
      chk(double_width_mode, width_select);
      host_u.pins(1'b1, 1'b0, 1'b1);
      for (int il = 0; il < 2; il++) begin
         for (int bl = 4; bl <= 8; bl += 4) begin
            start_read(il[0], bl, 1'b0);
            word = {16'h0000, col_key[0] ? array_data[31:16] : array_data[15:0]};
            chk(dq_out, width_select ? array_data : word);
            beats(bl, bl);
            chk(burst_active, 1'b0);
         end
      end
      // Mask latency, then stop mid-burst
      start_read(1'b0, 8, 1'b0);
      host_u.pins(1'b1, 1'b1, 1'b1);
      tick(2);
      chk(dq_oe, 1'b1);
      tick(1);
      chk(dq_oe, 1'b0);
      host_u.cmd(4'h5, 13'h0000);
      tick(1);
      chk(burst_active, 1'b0);
      // Gate low mid-burst freezes state and ignores commands
      start_read(1'b1, 8, 1'b0);
      host_u.pins(1'b0, 1'b0, 1'b1);
      tick(2);
      chk(clock_suspend, 1'b1);
      chk(power_down, 1'b0);
      held = burst_addr;
      host_u.cmd(4'h7, ~row_key);
      tick(2);
      chk(burst_addr, held);
      chk(row_addr, row_key);
      host_u.pins(1'b1, 1'b0, 1'b1);
      tick(2);
      chk(clock_suspend, 1'b0);
      host_u.cmd(4'h5, 13'h0000);
      tick(1);
      chk(burst_active, 1'b0);
      tick(12);
      host_u.pins(1'b0, 1'b0, 1'b1);
      tick(3);
      chk(power_down, 1'b1);
      host_u.pins(1'b1, 1'b0, 1'b1);
      tick(2);
      chk(power_down, 1'b0);
      host_u.cmd(4'h3, ~row_key);
      host_u.cmd(4'hf, ~row_key);
      host_u.cmd(4'h5, ~row_key);
      tick(2);
      chk(row_addr, row_key);
      chk(col_addr, col_key);
      chk(burst_active, 1'b0);
      prog(1'b0, 13'h0123);
      prog(1'b1, 13'h0456);
      host_u.cmd(4'h8, 13'h1000);
      tick(1);
      chk(continuity_test, 1'b1);
      host_u.cmd(4'hf, 13'h1805);
      tick(1);
      chk(continuity_test, 1'b1);
      host_u.cmd(4'hf, 13'h0805);
      tick(1);
      chk(continuity_test, 1'b0);
      @(posedge sys_clk);
      array_data <= 32'hffff_ffff;
      start_read(1'b0, 4, 1'b1);
      chk(dq_out, 32'h0f96_3c5a);
      beats(4, 4);
      host_u.mode(8'h5b);
      chk(boot_mode, 1'b1);
      host_u.pins(1'b0, 1'b0, 1'b0);
      tick(6);
      chk(dq_oe, 1'b1);
      chk(dq_out[15:0], boot_data);
      host_u.pins(1'b0, 1'b1, 1'b0);
      tick(6);
      chk(dq_oe, 1'b0);
      host_u.pins(1'b1, 1'b1, 1'b1);
      prog(1'b0, 13'h0042);
      host_u.mode(8'h59);
      chk(boot_mode, 1'b0);
      end_of_test();
   end
endmodule // tb_sync_flash_command_decoder
